/* pkg/mii_pkg.sv */
// constants and types shared by the media-independent interface block
// Notes on behaviour
// [RQ1] transmit enable rises with first nibble, falls at next tx edge after last
// [RQ2] transmit data valid only under enable; serial mode drives bit 0 only
// [RQ3] enable, data and error are launched on transmit clock rising edges
// [RQ4] phy holds collision while it lasts; ignored in full duplex
// [RQ5] phy holds receive valid over the whole frame, ending before end symbols
// [RQ6] receive valid, data and error are sampled on receive clock rising edges
// [RQ7] receive data accepted only under valid; serial mode uses bit 0 only
// [RQ8] transmit error only meaningful with enable high in nibble mode
// [RQ9] receive error with valid marks the current frame bad; ignored otherwise (code also ignores it in serial mode)
// [RQ10] carrier sense high means the medium is busy
// [RQ11] management data pin is bidirectional, released to input after reset
// [RQ12] management clock is generated here and driven out
// [RQ13] in serial seven-wire mode management pin is grounded and unused
// [RQ14] a mode input selects serial bit 0 or four-bit nibble operation
package mii_pkg;
  localparam int unsigned SYS_CLK_PERIOD_NS = 10;
  localparam int unsigned MGMT_CLK_PERIOD_NS = 400;
  localparam int unsigned MGMT_HALF_CYCLES = MGMT_CLK_PERIOD_NS / 2 / SYS_CLK_PERIOD_NS;
  localparam int unsigned MGMT_CNT_W = 8;
  localparam int unsigned NIBBLE_W = 4;
  localparam int unsigned SYNC_W = 11;
  localparam logic [NIBBLE_W-1:0] NIBBLE_RESET = 4'h0;
  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_TAIL} tx_state_t;
endpackage : mii_pkg

/* rtl/pin_sync.sv */
// two flip-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign sync_out = sync_q;
endmodule : pin_sync

/* rtl/mii_phy_interface.sv */
// pin-level mac side of the media-independent interface to an external phy
`timescale 1ns/1ns
module mii_phy_interface (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic mode_nibble_in,
  input wire logic full_duplex_in,
  input wire logic [3:0] tx_data_in,
  input wire logic tx_valid_in,
  input wire logic tx_last_in,
  input wire logic tx_err_in,
  output logic tx_ready_out,
  output logic tx_underrun_out,
  output logic [3:0] rx_data_out,
  output logic rx_valid_out,
  output logic rx_done_out,
  output logic rx_frame_err_out,
  output logic collision_out,
  output logic medium_busy_out,
  input wire logic mgmt_drive_in,
  input wire logic mgmt_bit_in,
  output logic mgmt_bit_out,
  output logic mgmt_bit_valid_out,
  input wire logic phy_tx_clk,
  output logic tx_frame_en,
  output logic tx_bit0,
  output logic [2:0] tx_bits_upper,
  output logic tx_err_out,
  input wire logic collision_in,
  input wire logic carrier_sense_in,
  input wire logic phy_rx_clk,
  input wire logic rx_frame_valid,
  input wire logic rx_bit0,
  input wire logic [2:0] rx_bits_upper,
  input wire logic rx_err_in,
  input wire logic mgmt_data_io_in,
  output logic mgmt_data_io_out,
  output logic mgmt_data_io_oe,
  output logic mgmt_clk_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic [mii_pkg::SYNC_W-1:0] sync_w;
  logic txc_s, rxc_s, rxdv_s, rxer_s, col_s, crs_s, mdi_s;
  logic [3:0] rxd_s;
  pin_sync #(.W(mii_pkg::SYNC_W)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .async_in({phy_tx_clk, phy_rx_clk, rx_frame_valid, rx_bits_upper, rx_bit0,
               rx_err_in, collision_in, carrier_sense_in, mgmt_data_io_in}),
    .sync_out(sync_w)
  );
  assign {txc_s, rxc_s, rxdv_s, rxd_s, rxer_s, col_s, crs_s, mdi_s} = sync_w;

  // edge finding on the sampled phy clocks
  logic txc_prev_q, txc_prev_d, rxc_prev_q, rxc_prev_d;
  logic tx_edge, rx_edge;
  assign tx_edge = txc_s & ~txc_prev_q; // RQ3
  assign rx_edge = rxc_s & ~rxc_prev_q; // RQ6

  ////////////////////////////////////////////////////////////////////////////
  // transmit
  mii_pkg::tx_state_t tx_st_q, tx_st_d;
  logic en_q, en_d, err_q, err_d, under_q, under_d;
  logic [3:0] txd_q, txd_d;
  logic take;
  // a frame must leave one tx clock gap after its tail, so no nibble is taken then
  assign take = tx_edge & tx_valid_in & (tx_st_q != mii_pkg::TX_TAIL);
  assign tx_ready_out = take;
  always_comb begin
    tx_st_d = tx_st_q;
    en_d = en_q;
    err_d = err_q;
    txd_d = txd_q;
    under_d = 1'b0;
    if (tx_edge) begin
      case (tx_st_q)
        mii_pkg::TX_IDLE: begin
          if (tx_valid_in) begin
            en_d = 1'b1; // RQ1
            txd_d = tx_data_in;
            err_d = tx_err_in;
            tx_st_d = tx_last_in ? mii_pkg::TX_TAIL : mii_pkg::TX_SEND;
          end
        end
        mii_pkg::TX_SEND: begin
          if (tx_valid_in) begin
            txd_d = tx_data_in;
            err_d = tx_err_in;
            if (tx_last_in) begin
              tx_st_d = mii_pkg::TX_TAIL;
            end
          end else begin
            // starved source: frame is cut short rather than padded
            en_d = 1'b0;
            err_d = 1'b0;
            txd_d = mii_pkg::NIBBLE_RESET;
            under_d = 1'b1;
            tx_st_d = mii_pkg::TX_IDLE;
          end
        end
        default: begin
          en_d = 1'b0; // RQ1
          err_d = 1'b0;
          txd_d = mii_pkg::NIBBLE_RESET;
          tx_st_d = mii_pkg::TX_IDLE;
        end
      endcase
    end
  end
  assign tx_frame_en = en_q;
  assign tx_bit0 = en_q & txd_q[0]; // RQ2
  assign tx_bits_upper = (en_q & mode_nibble_in) ? txd_q[3:1] : 3'h0; // RQ2 RQ14
  assign tx_err_out = err_q & en_q & mode_nibble_in; // RQ8
  assign tx_underrun_out = under_q;

  ////////////////////////////////////////////////////////////////////////////
  // receive
  logic [3:0] rxd_q, rxd_d;
  logic rxv_q, rxv_d, in_frame_q, in_frame_d, bad_q, bad_d, done_q, done_d;
  logic ferr_q, ferr_d;
  always_comb begin
    rxd_d = rxd_q;
    rxv_d = 1'b0;
    done_d = 1'b0;
    in_frame_d = in_frame_q;
    bad_d = bad_q;
    ferr_d = ferr_q;
    if (rx_edge) begin
      if (rxdv_s) begin
        rxd_d = mode_nibble_in ? rxd_s : {3'h0, rxd_s[0]}; // RQ7 RQ14
        rxv_d = 1'b1; // RQ7
        in_frame_d = 1'b1;
        // first nibble restarts the flag; error on that nibble still counts
        bad_d = (in_frame_q & bad_q) | (rxer_s & mode_nibble_in); // RQ9
      end else if (in_frame_q) begin
        in_frame_d = 1'b0;
        done_d = 1'b1;
        ferr_d = bad_q;
        bad_d = 1'b0;
      end
    end
  end
  assign rx_data_out = rxd_q;
  assign rx_valid_out = rxv_q;
  assign rx_done_out = done_q;
  assign rx_frame_err_out = ferr_q;

  ////////////////////////////////////////////////////////////////////////////
  // line status
  logic col_q, col_d, busy_q, busy_d;
  always_comb begin
    col_d = col_s & ~full_duplex_in; // RQ4
    busy_d = crs_s; // RQ10
  end
  assign collision_out = col_q;
  assign medium_busy_out = busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // management clock and data pin
  logic [mii_pkg::MGMT_CNT_W-1:0] div_q, div_d;
  logic mdc_q, mdc_d, mdo_q, mdo_d, mdoe_q, mdoe_d, mbit_q, mbit_d, mval_q, mval_d;
  logic half_tick;
  assign half_tick = (div_q == mii_pkg::MGMT_CNT_W'(mii_pkg::MGMT_HALF_CYCLES - 1));
  always_comb begin
    div_d = half_tick ? '0 : div_q + 1'b1;
    mdc_d = half_tick ? ~mdc_q : mdc_q; // RQ12
    mdo_d = mdo_q;
    mdoe_d = mdoe_q;
    mbit_d = mbit_q;
    mval_d = 1'b0;
    if (half_tick & mdc_q) begin
      // launch on the falling edge so the phy sees stable data at the rise
      mdoe_d = mgmt_drive_in & mode_nibble_in; // RQ11 RQ13
      mdo_d = mgmt_bit_in;
    end
    if (half_tick & ~mdc_q) begin
      mbit_d = mdi_s; // RQ11
      mval_d = 1'b1;
    end
  end
  assign mgmt_clk_out = mdc_q;
  assign mgmt_data_io_out = mdo_q;
  assign mgmt_data_io_oe = mdoe_q;
  assign mgmt_bit_out = mbit_q;
  assign mgmt_bit_valid_out = mval_q;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    txc_prev_d = txc_s;
    rxc_prev_d = rxc_s;
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      txc_prev_q <= 1'b0;
      rxc_prev_q <= 1'b0;
      tx_st_q <= mii_pkg::TX_IDLE;
      en_q <= 1'b0;
      err_q <= 1'b0;
      txd_q <= mii_pkg::NIBBLE_RESET;
      under_q <= 1'b0;
      rxd_q <= mii_pkg::NIBBLE_RESET;
      rxv_q <= 1'b0;
      in_frame_q <= 1'b0;
      bad_q <= 1'b0;
      done_q <= 1'b0;
      ferr_q <= 1'b0;
      col_q <= 1'b0;
      busy_q <= 1'b0;
      div_q <= '0;
      mdc_q <= 1'b0;
      mdo_q <= 1'b0;
      mdoe_q <= 1'b0; // RQ11
      mbit_q <= 1'b0;
      mval_q <= 1'b0;
    end else begin
      txc_prev_q <= txc_prev_d;
      rxc_prev_q <= rxc_prev_d;
      tx_st_q <= tx_st_d;
      en_q <= en_d;
      err_q <= err_d;
      txd_q <= txd_d;
      under_q <= under_d;
      rxd_q <= rxd_d;
      rxv_q <= rxv_d;
      in_frame_q <= in_frame_d;
      bad_q <= bad_d;
      done_q <= done_d;
      ferr_q <= ferr_d;
      col_q <= col_d;
      busy_q <= busy_d;
      div_q <= div_d;
      mdc_q <= mdc_d;
      mdo_q <= mdo_d;
      mdoe_q <= mdoe_d;
      mbit_q <= mbit_d;
      mval_q <= mval_d;
    end
  end
endmodule : mii_phy_interface

/* bench/mii_phy_interface_props.sv */
// assertion checker on the phy interface ports
`timescale 1ns/1ns
module mii_phy_interface_props (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic mode_nibble_in,
  input wire logic full_duplex_in,
  input wire logic tx_ready_out,
  input wire logic [3:0] rx_data_out,
  input wire logic rx_valid_out,
  input wire logic rx_done_out,
  input wire logic rx_frame_err_out,
  input wire logic collision_out,
  input wire logic mgmt_bit_valid_out,
  input wire logic tx_frame_en,
  input wire logic tx_bit0,
  input wire logic [2:0] tx_bits_upper,
  input wire logic tx_err_out,
  input wire logic mgmt_data_io_oe,
  input wire logic mgmt_clk_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  ////////////////////////////////////////
  AST_TX_ERR: assert property (tx_err_out |-> tx_frame_en && mode_nibble_in)
    else $error("tx error outside nibble frame");
  AST_TX_IDLE: assert property (!tx_frame_en |-> !tx_bit0 && tx_bits_upper == 3'h0)
    else $error("tx data outside frame");
  AST_TX_SERIAL: assert property (!mode_nibble_in |-> tx_bits_upper == 3'h0)
    else $error("upper tx bits in serial mode");
  AST_TX_LAUNCH: assert property (tx_ready_out |=> tx_frame_en)
    else $error("taken nibble not launched");
  AST_TX_RISE: assert property ($rose(tx_frame_en) |-> $past(tx_ready_out))
    else $error("enable rose without nibble");
  AST_COLL_FD: assert property ($past(full_duplex_in) |-> !collision_out)
    else $error("collision in full duplex");
  AST_RX_PULSE: assert property (rx_valid_out |=> !rx_valid_out [*8])
    else $error("rx nibbles too close");
  AST_RX_SERIAL: assert property (rx_valid_out && !mode_nibble_in |-> rx_data_out[3:1] == 3'h0)
    else $error("upper rx bits in serial mode");
  AST_MGMT_RST: assert property (disable iff (1'b0) !rstn_in |=> !mgmt_data_io_oe)
    else $error("mgmt pin driven after reset");
  AST_MGMT_SER: assert property ($rose(mgmt_data_io_oe) |-> $past(mode_nibble_in))
    else $error("mgmt pin driven in serial mode");
  AST_MDC_HALF: assert property ($changed(mgmt_clk_out) |=> $stable(mgmt_clk_out) [*8])
    else $error("mgmt clock half too short");
  cover property (tx_ready_out && !mode_nibble_in);
  cover property (rx_done_out && rx_frame_err_out);
  cover property (collision_out);
  cover property (mgmt_bit_valid_out && mgmt_data_io_oe);
endmodule : mii_phy_interface_props
bind mii_phy_interface mii_phy_interface_props i_props (.*);

/* bench/phy_model.sv */
// behavioural phy: link clocks, transmit capture, receive frames
`timescale 1ns/1ns
module phy_model (
  input wire logic tx_run_in,
  input wire logic tx_frame_en,
  input wire logic tx_bit0,
  input wire logic [2:0] tx_bits_upper,
  input wire logic tx_err_out,
  output logic phy_tx_clk,
  output logic phy_rx_clk,
  output logic rx_frame_valid,
  output logic rx_bit0,
  output logic [2:0] rx_bits_upper,
  output logic rx_err_in
);
  logic [4:0] got[$];
  // odd offset keeps transmit clock edges unrelated to the system clock
  initial begin
    {phy_tx_clk, phy_rx_clk, rx_frame_valid, rx_bit0, rx_bits_upper, rx_err_in} = '0;
    #37;
    forever #80 phy_tx_clk = tx_run_in & ~phy_tx_clk;
  end
  always @(posedge phy_tx_clk) if (tx_frame_en) got.push_back({tx_err_out, tx_bits_upper, tx_bit0});
  ////////////////////////////////////////
  // lead edge carries an error with valid low; released data inverts
  task automatic send(input logic [3:0] n[$], input int e);
    for (int i = -1; i <= n.size() + 2; i++) begin
      phy_rx_clk = 1'b0;
      rx_frame_valid = i >= 0 && i < n.size();
      rx_err_in = i == e || i == -1;
      {rx_bits_upper, rx_bit0} = rx_frame_valid ? n[i] : ~{rx_bits_upper, rx_bit0};
      #80 phy_rx_clk = 1'b1;
      #80;
    end
    phy_rx_clk = 1'b0;
  endtask : send
endmodule : phy_model

/* bench/mii_phy_interface_bench.sv */
// self-checking bench for the phy interface block
`timescale 1ns/1ns
`define CHK(nm, e, s) begin compares++; if ((e) !== (s)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module mii_phy_interface_bench;
  logic clk_sys_in, rstn_in, mode_nibble_in, full_duplex_in, tx_valid_in, tx_last_in;
  logic tx_err_in, tx_ready_out, tx_underrun_out, rx_valid_out, rx_done_out, rx_frame_err_out;
  logic collision_out, medium_busy_out, mgmt_drive_in, mgmt_bit_in, mgmt_bit_out;
  logic mgmt_bit_valid_out, phy_tx_clk, tx_frame_en, tx_bit0, tx_err_out, collision_in;
  logic carrier_sense_in, phy_rx_clk, rx_frame_valid, rx_bit0, rx_err_in, mgmt_data_io_in;
  logic mgmt_data_io_out, mgmt_data_io_oe, mgmt_clk_out, tx_run_in, phy_mgmt, rx_err_exp;
  logic [3:0] tx_data_in, rx_data_out, e4;
  logic [2:0] tx_bits_upper, rx_bits_upper;
  logic [3:0] rxq[$];
  logic [31:0] seed = 32'ha43e2897;
  int failures, compares, cyc;
  mii_phy_interface i_mii_phy_interface (.*);
  phy_model i_phy_model (.*);
  // far side toggles every cycle so a released pin never looks driven
  // serial seven-wire board grounds the pin
  assign mgmt_data_io_in = mgmt_data_io_oe ? mgmt_data_io_out : (mode_nibble_in & phy_mgmt);
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic complete_run();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  always @(posedge clk_sys_in) begin
    phy_mgmt <= ~phy_mgmt;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end
  always @(negedge clk_sys_in) begin
    if (rx_valid_out) begin
      e4 = rxq.pop_front();
      `CHK("rx_data", e4, rx_data_out)
    end
    if (rx_done_out) `CHK("rx_err", rx_err_exp, rx_frame_err_out)
  end
  ////////////////////////////////////////
  task automatic tx_frame(input int n, input logic nib);
    logic [4:0] exp[$];
    tx_run_in <= 1'b1;
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      {tx_valid_in, tx_last_in, tx_err_in, tx_data_in} <= {1'b1, i == n - 1, i == 3, seed[3:0]};
      exp.push_back(nib ? {i == 3, seed[3:0]} : {4'h0, seed[0]});
      do @(negedge clk_sys_in); while (!tx_ready_out);
      @(posedge clk_sys_in);
    end
    tx_valid_in <= 1'b0;
    do @(negedge clk_sys_in); while (tx_frame_en);
    tx_run_in <= 1'b0;
    `CHK("tx_count", exp.size(), i_phy_model.got.size())
    foreach (exp[i]) `CHK("tx_nibble", exp[i], i_phy_model.got[i])
    i_phy_model.got.delete();
  endtask : tx_frame
  task automatic rx_frame(input logic nib, input int e);
    logic [3:0] n[$];
    for (int i = 0; i < 9; i++) begin
      seed = lfsr(seed);
      n.push_back(seed[3:0]);
      rxq.push_back(nib ? seed[3:0] : {3'h0, seed[0]});
    end
    rx_err_exp = nib && e >= 0;
    i_phy_model.send(n, e);
    repeat (8) @(negedge clk_sys_in);
    `CHK("rx_left", 0, rxq.size())
  endtask : rx_frame
  initial begin
    {rstn_in, mode_nibble_in, full_duplex_in, tx_data_in, tx_valid_in, tx_last_in} = '0;
    {tx_err_in, mgmt_drive_in, mgmt_bit_in, collision_in, carrier_sense_in} = '0;
    {tx_run_in, phy_mgmt, failures, compares, cyc} = '0;
    repeat (6) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(negedge clk_sys_in);
    `CHK("oe_reset", 1'b0, mgmt_data_io_oe)
    for (int m = 1; m >= 0; m--) begin
      @(posedge clk_sys_in);
      mode_nibble_in <= m[0];
      tx_frame(7, m[0]);
      rx_frame(m[0], 2);
      rx_frame(m[0], -2);
    end
    // starved source: one nibble taken, then valid dropped mid-frame
    @(posedge clk_sys_in);
    tx_run_in <= 1'b1;
    {tx_valid_in, tx_last_in, tx_err_in} <= 3'b100;
    do @(negedge clk_sys_in); while (!tx_ready_out);
    @(posedge clk_sys_in);
    tx_valid_in <= 1'b0;
    do @(negedge clk_sys_in); while (tx_frame_en);
    tx_run_in <= 1'b0;
    `CHK("tx_underrun", 1'b1, tx_underrun_out)
    `CHK("tx_cut_count", 1, i_phy_model.got.size())
    i_phy_model.got.delete();
    @(posedge clk_sys_in);
    {collision_in, carrier_sense_in} <= 2'b11;
    repeat (5) @(negedge clk_sys_in);
    `CHK("coll", 1'b1, collision_out)
    `CHK("busy", 1'b1, medium_busy_out)
    @(posedge clk_sys_in);
    full_duplex_in <= 1'b1;
    repeat (5) @(negedge clk_sys_in);
    `CHK("coll_fd", 1'b0, collision_out)
    for (int b = 1; b >= 0; b--) begin
      @(posedge clk_sys_in);
      {mode_nibble_in, mgmt_drive_in, mgmt_bit_in} <= {2'b11, b[0]};
      repeat (2) do @(negedge clk_sys_in); while (!(mgmt_bit_valid_out && mgmt_data_io_oe));
      `CHK("mgmt_bit", b[0], mgmt_bit_out)
    end
    @(posedge clk_sys_in);
    mode_nibble_in <= 1'b0;
    repeat (50) @(negedge clk_sys_in);
    `CHK("mgmt_oe", 1'b0, mgmt_data_io_oe)
    complete_run();
  end
endmodule : mii_phy_interface_bench
